// ==== hdl/adccal_regbank.sv ====
/*
 * Channel 3 calibration registers, map checksum and reserved word behind
 * a serial register port, plus the corrected channel 3 result and its
 * data-ready pin.
 * Assumes: serial pins are asynchronous and much slower than clk_sys_in;
 * raw samples arrive from logic on clk_sys_in.
 */
// Operation
// [RULE_01] offset low byte in upper half, low reads zero
// [RULE_02] offset high word holds bits 23:8, resets zero
// [RULE_03] gain high word read/write, resets 8000h
// [RULE_04] gain low byte in upper half, low reads zero
// [RULE_05] checksum word read-only, resets zero; code loads zero, then 8000h from the stored words one cycle later
// [RULE_06] host writes only zero to reserved word
// [RULE_07] data output released while chip select high
// [RULE_08] host never selects two converters together
// [RULE_09] host selects converters one at a time
// [RULE_10] host shares clock, strobes all sync pins
// [RULE_11] host may watch one data-ready pin
// [RULE_12] unused sync pin tied high on board
// [RULE_13] host uses sync, data-ready or clock counting
// [RULE_14] chip select tied low only when alone
// [RULE_15] tied-low chip select needs checksum protection
// [RULE_16] result corrected by offset then gain
module adccal_regbank
   import adccal_pkg::*;
(
   input  wire logic        clk_sys_in,        // system clock, 20 MHz
   input  wire logic        reset_n_in,        // sync reset, active low
   input  wire logic        spi_cs_n_in,       // chip select pin, active low
   input  wire logic        spi_sclk_in,       // serial clock pin
   input  wire logic        spi_din_in,        // serial data in pin
   output logic             spi_dout_out,      // serial data out level
   output logic             spi_dout_oe_out,   // serial data out enable
   input  wire logic        sync_reset_n_in,   // sync pin, active low
   input  wire logic [23:0] ch3_raw_in,        // raw channel 3 result
   input  wire logic        ch3_raw_valid_in,  // raw result strobe
   output logic      [23:0] ch3_result_out,    // corrected channel 3 result
   output logic             data_ready_n_out   // data ready, active low
);

   logic [PIN_COUNT-1:0] pin_meta_q;
   logic [PIN_COUNT-1:0] pin_sync_q;
   logic                 sclk_prev_q;
   logic                 cs_prev_q;
   logic                 syncp_prev_q;
   logic                 sclk_rise;
   logic                 sclk_fall;
   logic                 cs_fall;
   logic                 sync_fall;
   logic                 cs_active;

   adccal_phase_t        phase_d, phase_q;
   logic [5:0]           cnt_d, cnt_q;
   logic [15:0]          rx_d, rx_q;
   logic [15:0]          tx_d, tx_q;
   logic [1:0]           op_d, op_q;
   logic [5:0]           addr_d, addr_q;
   logic [15:0]          ofs_hi_d, ofs_hi_q;
   logic [7:0]           ofs_lo_d, ofs_lo_q;
   logic [15:0]          gain_hi_d, gain_hi_q;
   logic [7:0]           gain_lo_d, gain_lo_q;
   logic [15:0]          csum_d, csum_q;
   logic [15:0]          rsvd_d, rsvd_q;
   logic                 ready_n_d, ready_n_q;
   logic [15:0]          rd_data;
   logic [15:0]          rx_next;
   adccal_cfg_t          cal_cfg;
   logic                 result_valid;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers; only the second stage is looked at
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         // idle pin levels: select high, clock low, sync high
         pin_meta_q   <= 4'h9;
         pin_sync_q   <= 4'h9;
         sclk_prev_q  <= 1'b0;
         cs_prev_q    <= 1'b1;
         syncp_prev_q <= 1'b1;
      end else begin
         pin_meta_q   <= {sync_reset_n_in, spi_din_in, spi_sclk_in, spi_cs_n_in};
         pin_sync_q   <= pin_meta_q;
         sclk_prev_q  <= pin_sync_q[PIN_SCLK];
         cs_prev_q    <= pin_sync_q[PIN_CS_N];
         syncp_prev_q <= pin_sync_q[PIN_SYNC_N];
      end
   end

   assign cs_active = !pin_sync_q[PIN_CS_N];
   assign sclk_rise = cs_active && pin_sync_q[PIN_SCLK] && !sclk_prev_q;
   assign sclk_fall = cs_active && !pin_sync_q[PIN_SCLK] && sclk_prev_q;
   assign cs_fall   = cs_prev_q && !pin_sync_q[PIN_CS_N];
   assign sync_fall = syncp_prev_q && !pin_sync_q[PIN_SYNC_N];

   ////////////////////////////////////////////////////////////////////////
   // read mux
   always_comb begin
      case (addr_q)
         ADDR_OFS_HIGH:     rd_data = ofs_hi_q;
         // [RULE_01] low byte zero
         ADDR_OFS_LOW:      rd_data = {ofs_lo_q, RSVD_LOW_BYTE};
         ADDR_GAIN_HIGH:    rd_data = gain_hi_q;
         // [RULE_04] low byte zero
         ADDR_GAIN_LOW:     rd_data = {gain_lo_q, RSVD_LOW_BYTE};
         ADDR_MAP_CHECKSUM: rd_data = csum_q;
         ADDR_RSVD_ZERO:    rd_data = rsvd_q;
         default:           rd_data = 16'h0000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // frame sequencer and register writes
   always_comb begin
      phase_d   = phase_q;
      cnt_d     = cnt_q;
      rx_d      = rx_q;
      tx_d      = tx_q;
      op_d      = op_q;
      addr_d    = addr_q;
      ofs_hi_d  = ofs_hi_q;
      ofs_lo_d  = ofs_lo_q;
      gain_hi_d = gain_hi_q;
      gain_lo_d = gain_lo_q;
      rsvd_d    = rsvd_q;
      rx_next   = {rx_q[14:0], pin_sync_q[PIN_DIN]};
      // checksum follows the stored words; host writes never reach it
      // [RULE_05] read-only checksum
      csum_d    = ofs_hi_q ^ {ofs_lo_q, RSVD_LOW_BYTE} ^ gain_hi_q
                  ^ {gain_lo_q, RSVD_LOW_BYTE} ^ rsvd_q;

      case (phase_q)
         PH_IDLE: begin
            cnt_d = 6'h00;
            tx_d  = 16'h0000;
            if (cs_active) begin
               phase_d = PH_CMD;
            end
         end
         PH_CMD: begin
            if (sclk_rise) begin
               rx_d  = rx_next;
               cnt_d = cnt_q + 6'h01;
               if (cnt_q + 6'h01 == CNT_CMD_DONE) begin
                  op_d    = rx_next[CMD_OP_POS +: 2];
                  addr_d  = rx_next[CMD_ADDR_POS +: 6];
                  phase_d = PH_DATA;
               end
            end
         end
         PH_DATA: begin
            // load read data once the address is known
            if (cnt_q == CNT_CMD_DONE && !sclk_rise && op_q == CMD_OP_READ) begin
               tx_d = rd_data;
            end
            if (sclk_fall && cnt_q > CNT_CMD_DONE) begin
               tx_d = {tx_q[14:0], 1'b0};
            end
            if (sclk_rise) begin
               rx_d  = rx_next;
               cnt_d = cnt_q + 6'h01;
               if (cnt_q + 6'h01 == CNT_FRAME_DONE) begin
                  phase_d = PH_DONE;
                  if (op_q == CMD_OP_WRITE) begin
                     case (addr_q)
                        // [RULE_02] offset bits 23:8
                        ADDR_OFS_HIGH:  ofs_hi_d  = rx_next;
                        // [RULE_01] keep upper byte
                        ADDR_OFS_LOW:   ofs_lo_d  = rx_next[15:8];
                        // [RULE_03] gain bits 23:8
                        ADDR_GAIN_HIGH: gain_hi_d = rx_next;
                        // [RULE_04] keep upper byte
                        ADDR_GAIN_LOW:  gain_lo_d = rx_next[15:8];
                        // stored as written; zero is the host's duty
                        ADDR_RSVD_ZERO: rsvd_d    = rx_next;
                        default:        rsvd_d    = rsvd_q;
                     endcase
                  end
               end
            end
         end
         PH_DONE: begin
            if (sclk_fall) begin
               tx_d = 16'h0000;
            end
         end
         default: begin
            phase_d = PH_IDLE;
         end
      endcase

      // deselect aborts any partial frame without writing
      if (!cs_active) begin
         phase_d = PH_IDLE;
         cnt_d   = 6'h00;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         phase_q   <= PH_IDLE;
         cnt_q     <= 6'h00;
         rx_q      <= 16'h0000;
         tx_q      <= 16'h0000;
         op_q      <= 2'h0;
         addr_q    <= 6'h00;
         ofs_hi_q  <= RST_OFS_HIGH;
         ofs_lo_q  <= RST_OFS_LOW;
         gain_hi_q <= RST_GAIN_HIGH;
         gain_lo_q <= RST_GAIN_LOW;
         csum_q    <= RST_CHECKSUM;
         rsvd_q    <= RST_RSVD;
      end else begin
         phase_q   <= phase_d;
         cnt_q     <= cnt_d;
         rx_q      <= rx_d;
         tx_q      <= tx_d;
         op_q      <= op_d;
         addr_q    <= addr_d;
         ofs_hi_q  <= ofs_hi_d;
         ofs_lo_q  <= ofs_lo_d;
         gain_hi_q <= gain_hi_d;
         gain_lo_q <= gain_lo_d;
         csum_q    <= csum_d;
         rsvd_q    <= rsvd_d;
      end
   end

   // [RULE_07] release line when deselected
   assign spi_dout_oe_out = cs_active;
   assign spi_dout_out    = tx_q[WORD_BITS-1];

   ////////////////////////////////////////////////////////////////////////
   // correction datapath and data-ready pin
   assign cal_cfg = {ofs_hi_q, ofs_lo_q, gain_hi_q, gain_lo_q};

   adccal_corr u_corr (
      .clk_sys_in       (clk_sys_in),
      .reset_n_in       (reset_n_in),
      .cfg_in           (cal_cfg),
      .raw_in           (ch3_raw_in),
      .raw_valid_in     (ch3_raw_valid_in),
      .result_out       (ch3_result_out),
      .result_valid_out (result_valid)
   );

   // a new result wins over a frame start or sync strobe in the same cycle
   always_comb begin
      ready_n_d = ready_n_q;
      if (cs_fall || sync_fall) begin
         ready_n_d = 1'b1;
      end
      if (result_valid) begin
         ready_n_d = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         ready_n_q <= 1'b1;
      end else begin
         ready_n_q <= ready_n_d;
      end
   end

   assign data_ready_n_out = ready_n_q;

endmodule : adccal_regbank

// ==== hdl/adccal_pkg.sv ====
/*
 * Constants, types and register map for the channel 3 calibration
 * register slice and its serial register port.
 * Assumes: 16-bit registers addressed by a 6-bit register address.
 */
package adccal_pkg;

   ////////////////////////////////////////////////////////////////////////
   // register addresses
   localparam logic [5:0]  ADDR_OFS_HIGH     = 6'h19;
   localparam logic [5:0]  ADDR_OFS_LOW      = 6'h1A;
   localparam logic [5:0]  ADDR_GAIN_HIGH    = 6'h1B;
   localparam logic [5:0]  ADDR_GAIN_LOW     = 6'h1C;
   localparam logic [5:0]  ADDR_MAP_CHECKSUM = 6'h3E;
   localparam logic [5:0]  ADDR_RSVD_ZERO    = 6'h3F;

   ////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [15:0] RST_OFS_HIGH      = 16'h0000;
   localparam logic [7:0]  RST_OFS_LOW       = 8'h00;
   localparam logic [15:0] RST_GAIN_HIGH     = 16'h8000;
   localparam logic [7:0]  RST_GAIN_LOW      = 8'h00;
   localparam logic [15:0] RST_CHECKSUM      = 16'h0000;
   localparam logic [15:0] RST_RSVD          = 16'h0000;
   localparam logic [7:0]  RSVD_LOW_BYTE     = 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // serial frame layout: command word then data word, msb first
   localparam int          WORD_BITS         = 16;
   localparam int          CMD_OP_POS        = 14;
   localparam int          CMD_ADDR_POS      = 8;
   localparam logic [1:0]  CMD_OP_WRITE      = 2'h1;
   localparam logic [1:0]  CMD_OP_READ       = 2'h2;
   localparam logic [5:0]  CNT_CMD_DONE      = 6'h10;
   localparam logic [5:0]  CNT_FRAME_DONE    = 6'h20;

   ////////////////////////////////////////////////////////////////////////
   // correction arithmetic
   localparam int          CAL_FRAC_BITS     = 23;
   localparam logic signed [26:0] SAMPLE_MAX = 27'sh07FFFFF;
   localparam logic signed [26:0] SAMPLE_MIN = -27'sh0800000;

   ////////////////////////////////////////////////////////////////////////
   // pin synchroniser bit positions
   localparam int          PIN_CS_N          = 0;
   localparam int          PIN_SCLK          = 1;
   localparam int          PIN_DIN           = 2;
   localparam int          PIN_SYNC_N        = 3;
   localparam int          PIN_COUNT         = 4;

   typedef struct packed {
      logic [23:0] offset;
      logic [23:0] gain;
   } adccal_cfg_t;

   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_CMD  = 2'b01,
      PH_DATA = 2'b10,
      PH_DONE = 2'b11
   } adccal_phase_t;

endpackage : adccal_pkg

// ==== hdl/adccal_corr.sv ====
/*
 * Channel 3 offset and gain correction of one conversion result.
 * Assumes: raw samples come from logic on the same clock; one cycle latency.
 */
module adccal_corr
   import adccal_pkg::*;
(
   input  wire logic        clk_sys_in,        // system clock
   input  wire logic        reset_n_in,        // sync reset, active low
   input  wire adccal_cfg_t cfg_in,            // offset and gain words
   input  wire logic [23:0] raw_in,            // raw two's complement result
   input  wire logic        raw_valid_in,      // raw result strobe
   output logic      [23:0] result_out,        // corrected result
   output logic             result_valid_out   // corrected result strobe
);

   logic signed [24:0] diff;
   logic signed [49:0] prod;
   logic signed [26:0] scaled;
   logic        [23:0] result_d;
   logic        [23:0] result_q;
   logic               valid_d;
   logic               valid_q;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      // [RULE_16] offset then gain
      diff   = $signed({raw_in[23], raw_in}) - $signed({cfg_in.offset[23], cfg_in.offset});
      prod   = diff * $signed({1'b0, cfg_in.gain});
      scaled = prod[49:CAL_FRAC_BITS];
      // saturate rather than wrap so a large gain cannot flip the sign
      if (scaled > SAMPLE_MAX) begin
         result_d = SAMPLE_MAX[23:0];
      end else if (scaled < SAMPLE_MIN) begin
         result_d = SAMPLE_MIN[23:0];
      end else begin
         result_d = scaled[23:0];
      end
      if (!raw_valid_in) begin
         result_d = result_q;
      end
      valid_d = raw_valid_in;
   end

   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         result_q <= 24'h000000;
         valid_q  <= 1'b0;
      end else begin
         result_q <= result_d;
         valid_q  <= valid_d;
      end
   end

   assign result_out       = result_q;
   assign result_valid_out = valid_q;

endmodule : adccal_corr

// ==== dv/adccal_regbank_asserts.sv ====
/*
 * Port checker for the calibration register slice: select release,
 * result strobe timing and data-ready clearing.
 * Assumes: bound into every adccal_regbank instance; sync reset active low.
 */
module adccal_regbank_asserts
   import adccal_pkg::*;
(
   input  wire logic        clk_sys_in,        // system clock
   input  wire logic        reset_n_in,        // sync reset, active low
   input  wire logic        spi_cs_n_in,       // chip select pin
   input  wire logic        spi_dout_oe_out,   // data out enable
   input  wire logic        sync_reset_n_in,   // sync pin
   input  wire logic        ch3_raw_valid_in,  // raw result strobe
   input  wire logic [23:0] ch3_result_out,    // corrected result
   input  wire logic        data_ready_n_out   // data ready, active low
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!reset_n_in);
   ////////////////////////////////////////////////////////////////////////
   // three samples cover the two-flop select synchroniser
   chk_dout_released: assert property (spi_cs_n_in [*3] |-> !spi_dout_oe_out)
      else $error("data out driven while deselected");
   chk_dout_driven: assert property ((!spi_cs_n_in) [*4] |-> spi_dout_oe_out)
      else $error("data out not driven while selected");
   chk_ready_latency: assert property (ch3_raw_valid_in |-> ##[1:3] !data_ready_n_out)
      else $error("data ready missing after raw strobe");
   chk_result_cause: assert property ($changed(ch3_result_out) |->
      $past(ch3_raw_valid_in, 1) || $past(ch3_raw_valid_in, 2) || $past(ch3_raw_valid_in, 3))
      else $error("result changed without raw strobe");
   chk_ready_cause: assert property ($fell(data_ready_n_out) |->
      $past(ch3_raw_valid_in, 1) || $past(ch3_raw_valid_in, 2) || $past(ch3_raw_valid_in, 3))
      else $error("data ready fell without raw strobe");
   chk_sync_clears: assert property ($fell(sync_reset_n_in) ##0
      (!ch3_raw_valid_in) [*6] |-> data_ready_n_out)
      else $error("sync edge did not clear data ready");
   cover property (ch3_raw_valid_in);
   cover property ($fell(spi_cs_n_in));
   cover property ($fell(sync_reset_n_in));
endmodule : adccal_regbank_asserts

bind adccal_regbank adccal_regbank_asserts u_asserts (
   .clk_sys_in       (clk_sys_in),
   .reset_n_in       (reset_n_in),
   .spi_cs_n_in      (spi_cs_n_in),
   .spi_dout_oe_out  (spi_dout_oe_out),
   .sync_reset_n_in  (sync_reset_n_in),
   .ch3_raw_valid_in (ch3_raw_valid_in),
   .ch3_result_out   (ch3_result_out),
   .data_ready_n_out (data_ready_n_out)
);

// ==== dv/adccal_host_model.sv ====
/*
 * Host model: drives frames on the serial register port and the sync pin.
 * Assumes: tasks called from the bench; every pin moves on a falling clk edge.
 */
module adccal_host_model
   import adccal_pkg::*;
(
   input  wire logic        clk_in,       // bench clock
   input  wire logic        dout_in,      // device data out level
   input  wire logic        dout_oe_in,   // device data out enable
   output logic             cs_n_out,     // chip select
   output logic             sclk_out,     // serial clock, idle low
   output logic             din_out,      // serial data to device
   output logic             sync_n_out,   // sync pin
   output logic             rd_done_out,  // read word captured
   output logic      [15:0] rd_word_out   // captured read word
);
   timeunit 1ns;
   timeprecision 1ns;
   logic line_q = 1'b0;
   logic line;
   // released line shows no stale level
   assign line = dout_oe_in ? dout_in : ~line_q;
   always @(posedge clk_in) line_q <= line;
   initial begin
      cs_n_out = 1'b1;
      sclk_out = 1'b0;
      din_out = 1'b0;
      sync_n_out = 1'b1;
      rd_done_out = 1'b0;
      rd_word_out = 16'h0000;
   end
   task automatic half();
      repeat (4) @(negedge clk_in);
   endtask : half
   // own select only, never tied low
   task automatic frame(input logic [31:0] bits, input int nbits);
      logic [15:0] rx;
      rx = 16'h0000;
      @(negedge clk_in);
      cs_n_out <= 1'b0;
      for (int i = 31; i >= 32 - nbits; i--) begin
         din_out <= bits[i];
         half();
         sclk_out <= 1'b1;
         if (i < 16) rx = {rx[14:0], line};
         half();
         sclk_out <= 1'b0;
      end
      half();
      cs_n_out <= 1'b1;
      rd_word_out <= rx;
      rd_done_out <= (bits[31:30] == CMD_OP_READ) && (nbits == 32);
      @(negedge clk_in);
      rd_done_out <= 1'b0;
      repeat (8) @(negedge clk_in);
   endtask : frame
   // sync held high, strobed to align
   task automatic pulse_sync();
      @(negedge clk_in);
      sync_n_out <= 1'b0;
      half();
      sync_n_out <= 1'b1;
   endtask : pulse_sync
endmodule : adccal_host_model

// ==== dv/adccal_tb.sv ====
/*
 * Self-checking bench for the calibration register slice and result path.
 * Assumes: host model drives the serial pins; bench drives raw samples.
 */
module testbench
   import adccal_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        cs_n, sclk, din, dout, dout_oe, sync_n, rd_done, ready_n;
   logic [15:0] rd_word;
   logic [23:0] raw = 24'h000000;
   logic        raw_valid = 1'b0;
   logic [23:0] result;
   logic [31:0] seed = 32'h6EEC51FE;
   logic [31:0] r;
   int          mismatches = 0;
   int          n_checks = 0;
   logic [23:0] reg_q[$];
   logic [23:0] res_q[$];
   logic [5:0]  addr_t [5] = '{ADDR_OFS_HIGH, ADDR_OFS_LOW, ADDR_GAIN_HIGH,
                               ADDR_GAIN_LOW, ADDR_RSVD_ZERO};
   logic [15:0] mdl [5] = '{16'h0000, 16'h0000, 16'h8000, 16'h0000, 16'h0000};
   initial begin
      forever #25 clk = ~clk;
   end
   adccal_regbank DUT (.clk_sys_in(clk), .reset_n_in(reset_n), .spi_cs_n_in(cs_n),
      .spi_sclk_in(sclk), .spi_din_in(din), .spi_dout_out(dout),
      .spi_dout_oe_out(dout_oe), .sync_reset_n_in(sync_n), .ch3_raw_in(raw),
      .ch3_raw_valid_in(raw_valid), .ch3_result_out(result), .data_ready_n_out(ready_n));
   adccal_host_model host (.clk_in(clk), .dout_in(dout), .dout_oe_in(dout_oe),
      .cs_n_out(cs_n), .sclk_out(sclk), .din_out(din), .sync_n_out(sync_n),
      .rd_done_out(rd_done), .rd_word_out(rd_word));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   function automatic logic [15:0] csum();
      return mdl[0] ^ mdl[1] ^ mdl[2] ^ mdl[3] ^ mdl[4];
   endfunction : csum
   function automatic logic [23:0] corr(input logic [23:0] x);
      longint p;
      p = (longint'($signed(x)) - longint'($signed({mdl[0], mdl[1][15:8]})))
          * longint'({mdl[2], mdl[3][15:8]});
      p = p >>> 23;
      if (p > 64'sh7FFFFF) p = 64'sh7FFFFF;
      if (p < -64'sh800000) p = -64'sh800000;
      return p[23:0];
   endfunction : corr
   task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
      n_checks++;
      if (exp !== got) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      host.frame({CMD_OP_WRITE, a, 8'h00, d}, 32);
   endtask : wr
   task automatic rd(input logic [5:0] a, input logic [15:0] e);
      reg_q.push_back({8'h00, e});
      host.frame({CMD_OP_READ, a, 8'h00, 16'h0000}, 32);
   endtask : rd
   // sync after each sample lets data ready rise so the next fall is seen
   task automatic sample(input logic [23:0] x);
      res_q.push_back(corr(x));
      @(negedge clk);
      raw <= x;
      raw_valid <= 1'b1;
      @(negedge clk);
      raw_valid <= 1'b0;
      repeat (6) @(negedge clk);
      host.pulse_sync();
      repeat (8) @(negedge clk);
   endtask : sample
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : complete_run
   ////////////////////////////////////////////////////////////////////////
   // only this device's data ready paces the result checks
   always @(posedge clk) begin
      if (rd_done === 1'b1) begin
         check("read word", reg_q.pop_front(), {8'h00, rd_word});
      end
      if ($fell(ready_n)) begin
         check("result", res_q.pop_front(), result);
      end
   end
   initial begin
      #3000000;
      mismatches++;
      $display("watchdog expired");
      complete_run();
   end
   initial begin
      repeat (8) @(negedge clk);
      reset_n <= 1'b1;
      repeat (4) @(negedge clk);
      for (int i = 0; i < 5; i++) rd(addr_t[i], mdl[i]);
      rd(ADDR_MAP_CHECKSUM, csum());
      r = rnd();
      sample(r[23:0]);
      for (int i = 0; i < 5; i++) begin
         r = (i == 4) ? 32'h0 : rnd();
         wr(addr_t[i], r[15:0]);
         mdl[i] = (i == 1 || i == 3) ? {r[15:8], 8'h00} : r[15:0];
      end
      r = rnd();
      wr(ADDR_MAP_CHECKSUM, r[15:0]);
      for (int i = 0; i < 5; i++) rd(addr_t[i], mdl[i]);
      rd(ADDR_MAP_CHECKSUM, csum());
      rd(6'h05, 16'h0000);
      // undefined opcode must leave the register alone
      host.frame({2'h3, ADDR_GAIN_HIGH, 8'h00, ~mdl[2]}, 32);
      host.frame({CMD_OP_WRITE, ADDR_GAIN_HIGH, 8'h00, ~mdl[2]}, 20);
      rd(ADDR_GAIN_HIGH, mdl[2]);
      for (int i = 0; i < 4; i++) begin
         r = rnd();
         sample(r[23:0]);
      end
      sample(24'h7FFFFF);
      sample(24'h800000);
      repeat (20) @(negedge clk);
      check("pending results", 24'h000000, 24'(res_q.size() + reg_q.size()));
      complete_run();
   end
endmodule : testbench
